/* File: src/scc_pkg.sv */
/*
 * Constants of the serial channel control block: register indices,
 * field positions, reset values and shift timing.
 * Assumes byte address = 4 * register index on the bus.
 */
package scc_pkg;
	// Register indices; byte address is four times the index
	localparam logic [15:0] IDX_STATUS = 16'h4320;
	localparam logic [15:0] IDX_TXD = 16'h4322;
	localparam logic [15:0] IDX_RXD = 16'h4324;
	localparam logic [15:0] IDX_CTL = 16'h4326;
	localparam logic [15:0] IDX_IRQ_STATUS = 16'h4328;
	localparam logic [15:0] IDX_IRQ_MASK = 16'h432A;

	// Control register fields
	localparam int CTL_ENABLE = 0;
	localparam int CTL_ROLE = 1;
	localparam int CTL_POL = 2;
	localparam int CTL_PHA = 3;
	localparam int CTL_TXIE = 4;
	localparam int CTL_RXIE = 5;
	localparam int CTL_ORDER = 8;
	localparam int CTL_CLKSRC = 9;
	localparam logic [15:0] CTL_USED = 16'h033F;
	localparam logic [15:0] CTL_RESET = 16'h0000;

	// Status register fields
	localparam int ST_TBE = 0;
	localparam int ST_RBF = 1;
	localparam int ST_BUSY = 2;

	// Interrupt status and mask fields
	localparam int IRQ_TX = 0;
	localparam int IRQ_RX = 1;
	localparam logic [1:0] IRQ_RESET = 2'h0;

	localparam logic [7:0] DATA_RESET = 8'h00;

	// Shift clock from peripheral clock divided by four
	localparam int PCLK_DIV = 4;
	localparam logic HALF_LAST = 1'((PCLK_DIV / 2) - 1);
	localparam logic [3:0] EDGE_LAST = 4'hF;

	// Cycles from a data pin to its synchronised copy
	localparam int SYNC_LAG = 4;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : scc_pkg

/* File: src/scc_channel.sv */
/*
 * One synchronous serial channel with its control, status, data and
 * interrupt registers, reached over AXI4-Lite.
 * Assumes a 200 MHz clock, pins asynchronous to it, and a timer pulse
 * input on the same clock.
 */
// How it works
// RULE_01: clock source: PCLK/4 or timer channel 0
// RULE_02: bit order select: MSB or LSB first
// RULE_03: receive-full event raises request when enabled
// RULE_04: transmit-empty event raises request when enabled
// RULE_05: phase bit picks launch or capture first
// RULE_06: polarity bit sets idle level of clock
// RULE_07: role bit one makes master with internal clock
// RULE_08: slave shifts only on master's clock
// RULE_09: enable bit starts channel; clear stops it
// RULE_10: software disables before changing mode bits
// RULE_11: software avoids control access during transfers
// RULE_12: unused control bits read as zero
// RULE_13: software writes zero to reserved bits
// RULE_14: busy: master transfer or slave select low
// RULE_15: receive full set on load, cleared by read
// RULE_16: usual four-mode phase and polarity behaviour
`timescale 1ns/1ps
module scc_channel #(
	parameter int ADDR_W = 18
) (
	// Clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// AXI4-Lite write address
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Timer channel 0 output pulse, same clock
	input wire logic eight_bit_timer_ch0,
	// Serial link pins
	input wire logic sclk_in,
	output logic sclk_out,
	output logic sclk_oe,
	input wire logic sdi,
	output logic sdo,
	input wire logic ss_n,
	// Interrupt toward the interrupt controller
	output logic irq
);
	import scc_pkg::*;

	logic [15:0] serial_control_reg;
	logic [7:0] tx_buf;
	logic [7:0] rx_buf;
	logic tx_full;
	logic rx_buffer_full_flag;
	logic [1:0] irq_status;
	logic [1:0] irq_mask;
	logic channel_enable;
	logic master_role_select;
	logic clock_polarity_select;
	logic clock_phase_select;
	logic tx_empty_irq_enable;
	logic rx_full_irq_enable;
	logic bit_order_select;
	logic clock_source_select;

	assign channel_enable = serial_control_reg[CTL_ENABLE];
	assign master_role_select = serial_control_reg[CTL_ROLE];
	assign clock_polarity_select = serial_control_reg[CTL_POL];
	assign clock_phase_select = serial_control_reg[CTL_PHA];
	assign tx_empty_irq_enable = serial_control_reg[CTL_TXIE];
	assign rx_full_irq_enable = serial_control_reg[CTL_RXIE];
	assign bit_order_select = serial_control_reg[CTL_ORDER];
	assign clock_source_select = serial_control_reg[CTL_CLKSRC];

	// Pin synchronisers: bit 0 data in, 1 clock in, 2 select
	logic [2:0] pin_raw;
	logic [2:0] sync1;
	logic [2:0] sync2;
	logic [2:0] sync3;
	logic [2:0] pin_q;
	assign pin_raw = {ss_n, sclk_in, sdi};

	for (genvar i = 0; i < 3; i++) begin : g_sync
		always_ff @(posedge clock or negedge arst_n) begin
			if (!arst_n) begin
				sync1[i] <= 1'b1;
				sync2[i] <= 1'b1;
				sync3[i] <= 1'b1;
				pin_q[i] <= 1'b1;
			end else begin
				sync1[i] <= pin_raw[i];
				sync2[i] <= sync1[i];
				sync3[i] <= sync2[i];
				if (sync2[i] == sync3[i]) begin
					pin_q[i] <= sync3[i];
				end
			end
		end
	end

	logic sclk_prev;
	logic ss_prev;
	logic ss_low;
	assign ss_low = ~pin_q[2];

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			sclk_prev <= 1'b1;
			ss_prev <= 1'b0;
		end else begin
			sclk_prev <= pin_q[1];
			ss_prev <= ss_low;
		end
	end

	function automatic logic out_bit(input logic [7:0] v, input logic lsb);
		return lsb ? v[0] : v[7];
	endfunction : out_bit

	function automatic logic [7:0] shift_on(input logic [7:0] v,
		input logic lsb);
		return lsb ? {1'b0, v[7:1]} : {v[6:0], 1'b0};
	endfunction : shift_on

	// Shift engine state
	logic active;
	logic [3:0] edge_cnt;
	logic [7:0] tx_sh;
	logic [7:0] rx_sh;
	logic half_cnt;
	logic tick;
	logic edge_go;
	logic is_cap;
	logic last;
	logic start_m;
	logic start_s;
	logic reload;
	logic load_now;
	logic done;
	logic tx_evt;
	logic [7:0] next_rx;
	logic [7:0] rx_word;
	logic [SYNC_LAG-1:0] cap_pipe;
	logic [SYNC_LAG-1:0] done_pipe;
	logic cap_now;
	logic rx_load;

	// RULE_01 clock source select
	assign tick = clock_source_select ? eight_bit_timer_ch0
		: (half_cnt == HALF_LAST);
	// RULE_08 slave edges only from input clock
	assign edge_go = active & (master_role_select ? tick
		: (ss_low & (pin_q[1] != sclk_prev)));
	// RULE_16 capture parity follows phase
	assign is_cap = (edge_cnt[0] == clock_phase_select);
	assign last = (edge_cnt == EDGE_LAST);
	assign start_m = channel_enable & master_role_select & ~active & tx_full;
	assign start_s = channel_enable & ~master_role_select & ss_low
		& ~ss_prev;
	assign reload = edge_go & last & (master_role_select ? tx_full : ss_low);
	assign load_now = start_m | start_s | reload;
	assign done = edge_go & last;
	assign tx_evt = load_now & tx_full;
	// RULE_02 capture order
	assign next_rx = bit_order_select ? {pin_q[0], rx_sh[7:1]}
		: {rx_sh[6:0], pin_q[0]};
	assign cap_now = master_role_select ? cap_pipe[SYNC_LAG-1]
		: (edge_go & is_cap);
	assign rx_load = master_role_select ? done_pipe[SYNC_LAG-1] : done;
	assign rx_word = cap_now ? next_rx : rx_sh;

	// Own clock sees sdi late: hold captures for the sync lag
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			cap_pipe <= '0;
			done_pipe <= '0;
		end else begin
			cap_pipe <= {cap_pipe[SYNC_LAG-2:0], edge_go & is_cap};
			done_pipe <= {done_pipe[SYNC_LAG-2:0], done};
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			half_cnt <= 1'b0;
		end else if (active & master_role_select) begin
			half_cnt <= half_cnt + 1'b1;
		end else begin
			half_cnt <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			active <= 1'b0;
			edge_cnt <= 4'h0;
			tx_sh <= DATA_RESET;
			rx_sh <= DATA_RESET;
			sdo <= 1'b0;
			sclk_out <= 1'b0;
			sclk_oe <= 1'b0;
		end else if (!channel_enable) begin
			// RULE_09 disabled channel stops
			active <= 1'b0;
			edge_cnt <= 4'h0;
			// RULE_06 idle level from polarity
			sclk_out <= clock_polarity_select;
			sclk_oe <= 1'b0;
		end else begin
			// RULE_07 master drives the clock
			sclk_oe <= master_role_select;
			if (edge_go) begin
				edge_cnt <= edge_cnt + 4'h1;
				if (master_role_select) begin
					sclk_out <= ~sclk_out;
				end
				// RULE_05 launch on non-capture edges except the last edge
				if (!is_cap && !last) begin
					sdo <= out_bit(tx_sh, bit_order_select);
					tx_sh <= shift_on(tx_sh, bit_order_select);
				end
			end
			// RULE_05 master captures after the sync lag, slave on the edge
			if (cap_now) begin
				rx_sh <= next_rx;
			end
			if (done) begin
				active <= reload;
			end
			if (load_now) begin
				active <= 1'b1;
				edge_cnt <= 4'h0;
				if (clock_phase_select) begin
					tx_sh <= tx_buf;
				end else begin
					sdo <= out_bit(tx_buf, bit_order_select);
					tx_sh <= shift_on(tx_buf, bit_order_select);
				end
			end
			if (!master_role_select && !ss_low) begin
				active <= 1'b0;
				edge_cnt <= 4'h0;
			end
		end
	end

	// Bus handshake state
	logic aw_full;
	logic w_full;
	logic [ADDR_W-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic do_write;
	logic rd_take;

	assign do_write = aw_full & w_full & ~s_axi_bvalid;
	assign rd_take = s_axi_arvalid & s_axi_arready;

	function automatic logic hit(input logic [ADDR_W-1:0] a,
		input logic [15:0] idx);
		return a == ADDR_W'({idx, 2'b00});
	endfunction : hit

	function automatic logic [15:0] merge(input logic [15:0] old,
		input logic [31:0] d, input logic [3:0] s);
		return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction : merge

	logic wr_ctl;
	logic wr_txd;
	logic wr_ist;
	logic wr_msk;
	assign wr_ctl = do_write & hit(aw_addr, IDX_CTL);
	assign wr_txd = do_write & hit(aw_addr, IDX_TXD) & w_strb[0];
	assign wr_ist = do_write & hit(aw_addr, IDX_IRQ_STATUS);
	assign wr_msk = do_write & hit(aw_addr, IDX_IRQ_MASK);

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			aw_full <= 1'b0;
			w_full <= 1'b0;
			aw_addr <= '0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr <= s_axi_awaddr;
				aw_full <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
				w_full <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				aw_full <= 1'b0;
				w_full <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (hit(aw_addr, IDX_CTL) | hit(aw_addr, IDX_TXD)
					| hit(aw_addr, IDX_IRQ_STATUS) | hit(aw_addr, IDX_IRQ_MASK))
					? RESP_OKAY : RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else begin
			if (rd_take) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= RESP_OKAY;
				s_axi_rdata <= 32'h0000_0000;
				if (hit(s_axi_araddr, IDX_STATUS)) begin
					// RULE_14 busy by role
					s_axi_rdata[ST_BUSY] <= master_role_select ? active : ss_low;
					s_axi_rdata[ST_RBF] <= rx_buffer_full_flag;
					s_axi_rdata[ST_TBE] <= ~tx_full;
				end else if (hit(s_axi_araddr, IDX_TXD)) begin
					s_axi_rdata[7:0] <= tx_buf;
				end else if (hit(s_axi_araddr, IDX_RXD)) begin
					s_axi_rdata[7:0] <= rx_buf;
				end else if (hit(s_axi_araddr, IDX_CTL)) begin
					// RULE_12 unused bits read zero
					s_axi_rdata[15:0] <= serial_control_reg & CTL_USED;
				end else if (hit(s_axi_araddr, IDX_IRQ_STATUS)) begin
					s_axi_rdata[1:0] <= irq_status;
				end else if (hit(s_axi_araddr, IDX_IRQ_MASK)) begin
					s_axi_rdata[1:0] <= irq_mask;
				end else begin
					s_axi_rresp <= RESP_SLVERR;
				end
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			serial_control_reg <= CTL_RESET;
			irq_mask <= IRQ_RESET;
		end else begin
			if (wr_ctl) begin
				serial_control_reg <= merge(serial_control_reg, w_data, w_strb)
					& CTL_USED;
			end
			if (wr_msk && w_strb[0]) begin
				irq_mask <= w_data[1:0];
			end
		end
	end

	// Transmit buffer; a write in the load cycle keeps the new byte
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			tx_buf <= DATA_RESET;
			tx_full <= 1'b0;
		end else if (wr_txd) begin
			tx_buf <= w_data[7:0];
			tx_full <= 1'b1;
		end else if (tx_evt) begin
			tx_full <= 1'b0;
		end
	end

	// RULE_15 receive full, load beats read
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rx_buf <= DATA_RESET;
			rx_buffer_full_flag <= 1'b0;
		end else if (rx_load) begin
			rx_buf <= rx_word;
			rx_buffer_full_flag <= 1'b1;
		end else if (rd_take && hit(s_axi_araddr, IDX_RXD)) begin
			rx_buffer_full_flag <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			irq_status <= IRQ_RESET;
			irq <= 1'b0;
		end else begin
			for (int b = 0; b < 2; b++) begin
				if (wr_ist && w_strb[0] && w_data[b]) begin
					irq_status[b] <= 1'b0;
				end
			end
			// RULE_03 receive-full request gated
			if (rx_load && rx_full_irq_enable) begin
				irq_status[IRQ_RX] <= 1'b1;
			end
			// RULE_04 transmit-empty request gated
			if (tx_evt && tx_empty_irq_enable) begin
				irq_status[IRQ_TX] <= 1'b1;
			end
			irq <= |(irq_status & irq_mask);
		end
	end
endmodule : scc_channel

/* File: verif/scc_channel_properties.sv */
/* Port checker of the serial channel: bus answers, link pins, irq.
   Assumes one clock domain; bound to the channel from the bench. */
`timescale 1ns/1ps
module scc_channel_checker
	import scc_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// Register bus
	input wire logic s_axi_awready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Link and interrupt
	input wire logic sclk_out,
	input wire logic sclk_oe,
	input wire logic irq
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!arst_n);
	a_read_answer: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
	a_read_hold: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_read_upper: assert property (
		s_axi_rvalid |-> s_axi_rdata[31:10] == 22'h000000)
		else $error("unused bits not zero");
	a_write_hold: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_ready_back: assert property (
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
		else $error("write channel not freed");
	a_oe_by_write: assert property (
		$changed(sclk_oe) |-> s_axi_bvalid || $past(s_axi_bvalid))
		else $error("clock drive changed without write");
	a_idle_by_write: assert property (
		!sclk_oe && $changed(sclk_out) |-> s_axi_bvalid || $past(s_axi_bvalid))
		else $error("idle clock level moved");
	a_irq_fall: assert property (
		$fell(irq) |-> s_axi_bvalid || $past(s_axi_bvalid))
		else $error("irq fell without write");
	c_irq_up: cover property ($rose(irq));
	c_slverr: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
	c_toggle: cover property (sclk_oe && $changed(sclk_out));
endmodule : scc_channel_checker

/* File: verif/scc_link_peer.sv */
/* Link peer: external serial partner paced by the channel's clock or the bench's.
   Assumes mode inputs are set before each load pulse. */
`timescale 1ns/1ps
module scc_link_peer (
	// Link pins
	input wire logic sclk,
	input wire logic sdo,
	output logic sdi,
	// Mode and data
	input wire logic pol,
	input wire logic pha,
	input wire logic lsb,
	input wire logic load,
	input wire logic [7:0] tx,
	output logic [7:0] rx,
	output int n
);
	logic [7:0] sh;
	initial begin
		sdi = 1'b0;
		sh = 8'h00;
		rx = 8'h00;
		n = 0;
	end
	always @(posedge load) begin
		sh = tx;
		n = 0;
		sdi = lsb ? tx[0] : tx[7];
	end
	always @(sclk) begin
		if ((sclk != pol) ^ pha) begin
			rx = lsb ? {sdo, rx[7:1]} : {rx[6:0], sdo};
			n++;
		end else if (n < 8)
			sdi = lsb ? sh[n] : sh[7 - n];
		else
			sdi = ~sdi;
	end
endmodule : scc_link_peer

/* File: verif/tb_spi_channel_control.sv */
/* Bench of the serial channel: AXI4-Lite tasks, link peer, queued reads.
   Assumes scc_pkg, the checker and the peer are compiled first. */
`timescale 1ns/1ps
module tb_spi_channel_control;
	import scc_pkg::*;
	logic clock = 0;
	logic arst_n = 0;
	logic [17:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, ss_n = 1;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, sclk_out, sclk_oe, sdo, sdi, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp, tc = 0;
	logic pol = 0, pha = 0, lsb = 0, ld = 0, tmr_on = 0, tmr = 0, sck = 0;
	logic [7:0] txb = 0, rxb = 0, prx;
	logic [33:0] q[$];
	int fails = 0, num_checks = 0, seed = 80821, pn, i;
	always #2.5 clock = ~clock;
	always @(posedge clock) begin
		tc <= tc + 2'h1;
		tmr <= tmr_on && tc == 2'h0;
	end
	scc_channel uut (.clock, .arst_n, .s_axi_awaddr,
		.s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.eight_bit_timer_ch0(tmr), .sclk_in(sck), .sclk_out, .sclk_oe,
		.sdi, .sdo, .ss_n, .irq);
	scc_link_peer peer (.sclk(sclk_out | sck), .sdo, .sdi, .pol, .pha, .lsb,
		.load(ld), .tx(rxb), .rx(prx), .n(pn));
	task automatic close_out;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : close_out
	task automatic chk(input string nm, input logic [33:0] s, e);
		num_checks++;
		if (s !== e) begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic tmo;
		fails++;
		close_out();
	endtask : tmo
	task automatic wr(input logic [15:0] idx, d, input logic [1:0] er);
		int n;
		bit a, w;
		a = 1;
		w = 1;
		s_axi_awaddr <= {idx, 2'b00};
		s_axi_wdata <= {16'h0000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		for (n = 0; n < 99 && (a || w); n++) begin
			@(posedge clock);
			if (a && s_axi_awready) begin
				a = 0;
				s_axi_awvalid <= 1'b0;
			end
			if (w && s_axi_wready) begin
				w = 0;
				s_axi_wvalid <= 1'b0;
			end
		end
		@(posedge clock);
		s_axi_bready <= 1'b1;
		for (n = 0; n < 99; n++) begin
			@(posedge clock);
			if (s_axi_bvalid) break;
		end
		s_axi_bready <= 1'b0;
		if (n == 99 || a || w) tmo();
		chk("bresp", {32'h0, s_axi_bresp}, {32'h0, er});
	endtask : wr
	task automatic rd(input logic [15:0] idx, input logic [33:0] e);
		int n;
		q.push_back(e);
		s_axi_araddr <= {idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		for (n = 0; n < 99; n++) begin
			@(posedge clock);
			if (s_axi_arready) break;
		end
		s_axi_arvalid <= 1'b0;
		@(posedge clock);
		s_axi_rready <= 1'b1;
		for (n = 0; n < 99; n++) begin
			@(posedge clock);
			if (s_axi_rvalid) break;
		end
		s_axi_rready <= 1'b0;
		if (n == 99) tmo();
	endtask : rd
	// Oldest noted read result against each read answer
	always @(posedge clock)
		if (s_axi_rvalid && s_axi_rready)
			chk("rdata", {s_axi_rresp, s_axi_rdata}, q.pop_front());
	task automatic xfer(input logic [4:0] m);
		int n;
		logic [15:0] c;
		c = {6'h00, m[3], m[2], 2'b00, m[4], m[4], m[0], m[1], 2'b10};
		pha = m[0];
		pol = m[1];
		lsb = m[2];
		txb = 8'($random(seed));
		rxb = 8'($random(seed));
		wr(IDX_CTL, c, RESP_OKAY);
		wr(IDX_CTL, c | 16'h0001, RESP_OKAY);
		wr(IDX_IRQ_MASK, 16'h0002, RESP_OKAY);
		chk("sclk_out", {33'h0, sclk_out}, {33'h0, m[1]});
		chk("sclk_oe", {33'h0, sclk_oe}, 34'h1);
		ld <= 1'b1;
		@(posedge clock);
		ld <= 1'b0;
		wr(IDX_TXD, {8'h00, txb}, RESP_OKAY);
		rd(IDX_STATUS, 34'h5);
		chk("irq", {33'h0, irq}, 34'h0);
		if (m[3]) begin
			repeat (20) @(posedge clock);
			chk("sclk_out", {33'h0, sclk_out}, {33'h0, m[1]});
			tmr_on <= 1'b1;
		end
		for (n = 0; n < 999 && !(pn == 8 && sclk_out === m[1]); n++)
			@(posedge clock);
		if (n == 999) tmo();
		repeat (8) @(posedge clock);
		chk("peer_rx", {26'h0, prx}, {26'h0, txb});
		chk("irq", {33'h0, irq}, {33'h0, m[4]});
		rd(IDX_STATUS, 34'h3);
		rd(IDX_RXD, {26'h0, rxb});
		rd(IDX_STATUS, 34'h1);
		rd(IDX_IRQ_STATUS, {32'h0, m[4], m[4]});
		wr(IDX_IRQ_STATUS, 16'h0003, RESP_OKAY);
		@(posedge clock);
		chk("irq", {33'h0, irq}, 34'h0);
		tmr_on <= 1'b0;
		wr(IDX_CTL, c, RESP_OKAY);
	endtask : xfer
	initial begin
		repeat (10) @(posedge clock);
		arst_n <= 1'b1;
		rd(IDX_CTL, {18'h0, CTL_RESET});
		rd(IDX_STATUS, 34'h1);
		rd(IDX_RXD, {26'h0, DATA_RESET});
		rd(IDX_IRQ_MASK, 34'h0);
		rd(16'h432C, {RESP_SLVERR, 32'h0});
		wr(IDX_STATUS, 16'h0007, RESP_SLVERR);
		wr(IDX_CTL, 16'h033E, RESP_OKAY);
		rd(IDX_CTL, {18'h0, CTL_USED & 16'h033E});
		$display("test registers done");
		for (i = 0; i < 32; i++)
			xfer(5'(i));
		$display("test transfers done");
		wr(IDX_CTL, 16'h0000, RESP_OKAY);
		wr(IDX_CTL, 16'h0001, RESP_OKAY);
		pol = 1'b0;
		pha = 1'b0;
		lsb = 1'b0;
		rxb = 8'($random(seed));
		ld <= 1'b1;
		@(posedge clock);
		ld <= 1'b0;
		ss_n <= 1'b0;
		repeat (8) @(posedge clock);
		rd(IDX_STATUS, 34'h5);
		for (i = 0; i < 16; i++) begin
			sck <= ~sck;
			repeat (8) @(posedge clock);
		end
		repeat (8) @(posedge clock);
		chk("slave_tx", {26'h0, prx}, {26'h0, txb});
		rd(IDX_RXD, {26'h0, rxb});
		ss_n <= 1'b1;
		repeat (8) @(posedge clock);
		rd(IDX_STATUS, 34'h1);
		wr(IDX_CTL, 16'h0000, RESP_OKAY);
		wr(IDX_CTL, 16'h0002, RESP_OKAY);
		wr(IDX_CTL, 16'h0003, RESP_OKAY);
		@(posedge clock);
		chk("sclk_oe", {33'h0, sclk_oe}, 34'h1);
		wr(IDX_CTL, 16'h0002, RESP_OKAY);
		@(posedge clock);
		chk("sclk_oe", {33'h0, sclk_oe}, 34'h0);
		$display("test slave and stop done");
		close_out();
	end
endmodule : tb_spi_channel_control
bind scc_channel scc_channel_checker chk_i (.clock, .arst_n,
	.s_axi_awready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
	.s_axi_rvalid, .s_axi_rready, .sclk_out, .sclk_oe, .irq);
